/* rtl/timebase_rtc_watchdog.v */
`timescale 1ns/1ps
`include "timebase_rtc_map.vh"
module timebase_rtc_watchdog #(
  parameter CHRON_WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // crystal tick, one bus cycle per crystal edge
  input wire crystalTick,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timebase outputs
  output reg tick1kHz,
  output reg tick2kHz,
  // system
  output reg interruptRequest,
  output reg watchdogReset
);
  // timebase_control_register
  reg rtcEnable_q;
  reg chronClear_q;
  reg [1:0] watchdogRateSelect_q;
  reg halve_q;
  reg xtal32_q;
  reg firstWriteDone_q;
  // rtccr
  reg [7:0] rtcControl_q;
  // status, alarm
  reg [5:0] status_q;
  reg [5:0] alarmMin_q;
  reg [4:0] alarmHour_q;
  reg alarmHit_q;
  reg [23:0] wdCount_q;
  reg awHeld_q;
  reg wHeld_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg tbClearPulse;

  // halving stage ahead of the 4 kHz base tick
  wire crystalHalf;
  rate_divider #(.WIDTH(2)) u_base (
    .clk(clk), .reset(reset), .clear(tbClearPulse),
    .tickIn(crystalTick), .div(halve_q ? 2'h2 : 2'h1), .tickOut(crystalHalf)
  );
  // fractional step: 38.4 kHz is no whole multiple of 4 kHz
  reg [15:0] phase_q;
  reg tick4k;
  wire [15:0] xtalHz = xtal32_q ? `XTAL32_HZ : `XTAL38_HZ;
  wire [16:0] phaseSum = {1'b0, phase_q} + {1'b0, `BASE_HZ};
  wire phaseHit = phaseSum >= {1'b0, xtalHz};
  always @(posedge clk) begin
    if (reset || tbClearPulse) begin
      phase_q <= 16'h0000;
      tick4k <= 1'b0;
    end else begin
      tick4k <= crystalHalf && phaseHit;
      if (crystalHalf)
        phase_q <= phaseHit ? phaseSum[15:0] - xtalHz : phaseSum[15:0];
    end
  end

  // timebase chain from 4 kHz, all in bus clock domain
  reg [11:0] chain_q;
  reg [5:0] hundredCount_q;
  reg tick100_q;
  reg tick1_q;
  reg tick2_q;
  reg tick4_q;
  // 4 Hz from 100 Hz by dividing 25 with alternating 20/30 steps: uneven
  reg [4:0] quarter_q;
  reg quarterPhase_q;
  always @(posedge clk) begin
    if (reset || tbClearPulse) begin
      chain_q <= 12'h000;
      hundredCount_q <= 6'h00;
      quarter_q <= 5'h00;
      quarterPhase_q <= 1'b0;
      tick100_q <= 1'b0;
      tick1_q <= 1'b0;
      tick2_q <= 1'b0;
      tick4_q <= 1'b0;
      tick1kHz <= 1'b0;
      tick2kHz <= 1'b0;
    end else begin
      tick100_q <= 1'b0;
      tick1_q <= 1'b0;
      tick2_q <= 1'b0;
      tick4_q <= 1'b0;
      tick1kHz <= 1'b0;
      tick2kHz <= 1'b0;
      if (tick4k) begin
        chain_q <= (chain_q == 12'hF9F) ? 12'h000 : chain_q + 12'h001;
        tick2kHz <= chain_q[0];
        tick1kHz <= chain_q[1:0] == 2'h3;
        if (hundredCount_q == 6'h27) begin
          hundredCount_q <= 6'h00;
          tick100_q <= 1'b1;
          if (quarter_q == (quarterPhase_q ? 5'h1D : 5'h13)) begin
            quarter_q <= 5'h00;
            quarterPhase_q <= ~quarterPhase_q;
            tick4_q <= 1'b1; // 5 Hz then 3.3 Hz
          end else begin
            quarter_q <= quarter_q + 5'h01;
          end
        end else begin
          hundredCount_q <= hundredCount_q + 6'h01;
        end
        if (chain_q == 12'hF9F)
          tick1_q <= 1'b1;
        if (chain_q == 12'hF9F || chain_q == 12'h7CF)
          tick2_q <= 1'b1;
      end
    end
  end

  wire secTick = tick1_q && rtcEnable_q;
  wire secWrap;
  wire minWrap;
  wire [5:0] seconds;
  wire [5:0] minutes;
  wire [4:0] hours;
  modulo_counter #(.WIDTH(6)) u_sec (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .tick(secTick),
    .limit(6'h3B),
    .value(seconds),
    .wrap(secWrap)
  );
  modulo_counter #(.WIDTH(6)) u_min (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .tick(secWrap),
    .limit(6'h3B),
    .value(minutes),
    .wrap(minWrap)
  );
  modulo_counter #(.WIDTH(5)) u_hour (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .tick(minWrap),
    .limit(5'h17),
    .value(hours),
    .wrap()
  );

  // chronograph counts hundredths, flag every tenth
  reg [CHRON_WIDTH-1:0] chron_q;
  reg [3:0] tenth_q;
  wire chronRun = tick100_q && rtcControl_q[`RC_CHRCE];
  always @(posedge clk) begin
    if (reset || chronClear_q) begin
      chron_q <= {CHRON_WIDTH{1'b0}};
      tenth_q <= 4'h0;
    end else if (chronRun) begin
      chron_q <= chron_q + {{(CHRON_WIDTH-1){1'b0}}, 1'b1};
      tenth_q <= (tenth_q == 4'h9) ? 4'h0 : tenth_q + 4'h1;
    end
  end
  wire chronTenth = chronRun && tenth_q == 4'h9;

  reg periodicTick;
  always @* begin
    case (rtcControl_q[1:0])
      2'b01: periodicTick = tick1_q;
      2'b10: periodicTick = tick2_q;
      2'b11: periodicTick = tick4_q;
      default: periodicTick = 1'b0;
    endcase
  end

  // alarm on entry into the matching minute
  wire alarmMatch = (minutes == alarmMin_q) && (hours == alarmHour_q);
  always @(posedge clk) begin
    if (reset) begin
      alarmHit_q <= 1'b1; // zero alarm must not fire at release
    end else begin
      alarmHit_q <= alarmMatch;
    end
  end
  wire alarmEvent = alarmMatch && !alarmHit_q;

  // axi handshake
  wire writeFire = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_arready = !s_axi_rvalid;
  wire readFire = s_axi_arvalid && !s_axi_rvalid;
  // status cleared by reading it (then clear-on-read), sets win
  wire statusRead = readFire && s_axi_araddr == `OFS_RTCSR;
  wire [5:0] events = {minWrap, secWrap, secTick, chronTenth, alarmEvent, periodicTick};

  always @(posedge clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      rtcEnable_q <= 1'b0;
      chronClear_q <= 1'b0;
      watchdogRateSelect_q <= 2'b00;
      halve_q <= 1'b0;
      xtal32_q <= 1'b0;
      firstWriteDone_q <= 1'b0;
      tbClearPulse <= 1'b0;
      rtcControl_q <= 8'h00;
      alarmMin_q <= 6'h00;
      alarmHour_q <= 5'h00;
      status_q <= 6'h00;
    end else begin
      tbClearPulse <= 1'b0;
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (writeFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q > `OFS_SERVICE || awAddr_q[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
        if (wStrb_q[0]) begin
          case (awAddr_q)
            `OFS_TIMEBASE_CONTROL_REGISTER: begin
              rtcEnable_q <= wData_q[`TB_RTCE];
              chronClear_q <= wData_q[`TB_CHRONOGRAPH_CLEAR_BIT];
              tbClearPulse <= wData_q[`TB_CLR]; // self-clearing
              firstWriteDone_q <= 1'b1;
              if (!firstWriteDone_q) begin
                watchdogRateSelect_q <= wData_q[`TB_CRS_LO+1:`TB_CRS_LO];
                halve_q <= wData_q[`TB_X2];
                xtal32_q <= wData_q[`TB_XTAL32];
              end
            end
            `OFS_RTCCR: rtcControl_q <= wData_q[7:0];
            `OFS_ALMIN: alarmMin_q <= wData_q[5:0];
            `OFS_ALHOUR: alarmHour_q <= wData_q[4:0];
            default: begin
            end
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (readFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_TIMEBASE_CONTROL_REGISTER: s_axi_rdata <= {24'h000000, rtcEnable_q, 1'b0, chronClear_q, watchdogRateSelect_q, 1'b0,
                                     halve_q, xtal32_q};
          `OFS_RTCCR: s_axi_rdata <= {24'h000000, rtcControl_q};
          `OFS_RTCSR: s_axi_rdata <= {26'h0000000, status_q};
          `OFS_CHRON: s_axi_rdata <= {{(32-CHRON_WIDTH){1'b0}}, chron_q};
          `OFS_SEC: s_axi_rdata <= {26'h0000000, seconds};
          `OFS_MIN: s_axi_rdata <= {26'h0000000, minutes};
          `OFS_HOUR: s_axi_rdata <= {27'h0000000, hours};
          `OFS_ALMIN: s_axi_rdata <= {26'h0000000, alarmMin_q};
          `OFS_ALHOUR: s_axi_rdata <= {27'h0000000, alarmHour_q};
          `OFS_SERVICE: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // set wins over clear-on-read
      status_q <= (statusRead ? 6'h00 : status_q) | events;
    end
  end

  wire [5:0] enables = {rtcControl_q[`RC_HRIE], rtcControl_q[`RC_MINIE], rtcControl_q[`RC_SECIE],
                        rtcControl_q[`RC_CHRIE], rtcControl_q[`RC_ALIE], |rtcControl_q[1:0]};
  always @(posedge clk) begin
    if (reset)
      interruptRequest <= 1'b0;
    else
      interruptRequest <= |(status_q & enables);
  end

  // watchdog counts 4 Hz ticks, never stopped
  wire serviceWrite = writeFire && awAddr_q == `OFS_SERVICE;
  wire [23:0] wdLimit = {19'h00000, 5'h04} << watchdogRateSelect_q; // 4 ticks = 1 s at 32 kHz
  always @(posedge clk) begin
    if (reset) begin
      wdCount_q <= 24'h000000;
      watchdogReset <= 1'b0;
    end else begin
      watchdogReset <= 1'b0;
      if (serviceWrite || tbClearPulse) begin
        wdCount_q <= 24'h000000;
      end else if (tick4_q) begin
        if (wdCount_q + 24'h000001 >= wdLimit) begin
          wdCount_q <= 24'h000000;
          watchdogReset <= 1'b1;
        end else begin
          wdCount_q <= wdCount_q + 24'h000001;
        end
      end
    end
  end
endmodule

/* rtl/timebase_rtc_map.vh */
`ifndef TIMEBASE_RTC_MAP_VH
`define TIMEBASE_RTC_MAP_VH
// register byte offsets
`define OFS_TIMEBASE_CONTROL_REGISTER 8'h00
`define OFS_RTCCR 8'h04
`define OFS_RTCSR 8'h08
`define OFS_CHRON 8'h0C
`define OFS_SEC 8'h10
`define OFS_MIN 8'h14
`define OFS_HOUR 8'h18
`define OFS_ALMIN 8'h1C
`define OFS_ALHOUR 8'h20
`define OFS_SERVICE 8'h24
// timebase control fields
`define TB_RTCE 7
`define TB_CLR 6
`define TB_CHRONOGRAPH_CLEAR_BIT 5
`define TB_CRS_LO 3
`define TB_X2 1
`define TB_XTAL32 0
// rtc control fields
`define RC_HRIE 7
`define RC_MINIE 6
`define RC_SECIE 5
`define RC_CHRIE 4
`define RC_CHRCE 3
`define RC_ALIE 2
`define RC_PRQ_LO 0
// status fields
`define ST_HRF 5
`define ST_MINF 4
`define ST_SECF 3
`define ST_CHRF 2
`define ST_ALF 1
`define ST_PRQF 0
// crystal frequencies and base tick rate in Hz
`define XTAL32_HZ 16'h7D00
`define XTAL38_HZ 16'h9600
`define BASE_HZ 16'h0FA0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/rate_divider.v */
`timescale 1ns/1ps
// emits a one-cycle pulse every div input pulses
module rate_divider #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire clear,
  // stream
  input wire tickIn,
  input wire [WIDTH-1:0] div,
  output reg tickOut
);
  reg [WIDTH-1:0] count_q;
  always @(posedge clk) begin
    if (reset || clear) begin
      count_q <= {WIDTH{1'b0}};
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count_q >= div - {{(WIDTH-1){1'b0}}, 1'b1}) begin
          count_q <= {WIDTH{1'b0}};
          tickOut <= 1'b1;
        end else begin
          count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* rtl/modulo_counter.v */
`timescale 1ns/1ps
// counts 0..limit on each tick, pulses wrap on rollover
module modulo_counter #(
  parameter WIDTH = 6
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire clear,
  // counting
  input wire tick,
  input wire [WIDTH-1:0] limit,
  output reg [WIDTH-1:0] value,
  output wire wrap
);
  assign wrap = tick && (value == limit);
  always @(posedge clk) begin
    if (reset || clear) begin
      value <= {WIDTH{1'b0}};
    end else if (wrap) begin
      value <= {WIDTH{1'b0}};
    end else if (tick) begin
      value <= value + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* tb/timebase_rtc_watchdog_asserts.sv */
`timescale 1ns/1ps
module timebase_rtc_watchdog_asserts (
  // clock and reset
  input wire clk,
  input wire reset,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // block outputs
  input wire tick1kHz,
  input wire tick2kHz,
  input wire interruptRequest,
  input wire watchdogReset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // even the slower 32 kHz crystal needs 16 ticks per 2 kHz period
  sequence s_quiet2;
    !tick2kHz [*8];
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) reset |=> !tick1kHz && !tick2kHz && !interruptRequest && !watchdogReset;
  endproperty
  property p_write_answer;
    s_write_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_read_answer;
    s_read_taken |=> s_axi_rvalid;
  endproperty
  property p_write_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_read_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_wdog_pulse;
    watchdogReset |=> !watchdogReset;
  endproperty
  property p_tick1_gap;
    tick1kHz |=> !tick1kHz [*8];
  endproperty
  property p_tick2_gap;
    $rose(tick2kHz) |=> s_quiet2;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active after reset");
  a_write_answer: assert property (p_write_answer)
    else $error("write answer late");
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
  a_write_stands: assert property (p_write_stands)
    else $error("write answer dropped");
  a_read_stands: assert property (p_read_stands)
    else $error("read answer dropped");
  a_wdog_pulse: assert property (p_wdog_pulse)
    else $error("watchdog pulse too long");
  a_tick1_gap: assert property (p_tick1_gap)
    else $error("1 kHz ticks too close");
  a_tick2_gap: assert property (p_tick2_gap)
    else $error("2 kHz ticks too close");
endmodule
bind timebase_rtc_watchdog timebase_rtc_watchdog_asserts u_chk (
  .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .tick1kHz, .tick2kHz, .interruptRequest, .watchdogReset
);

/* tb/cpu_bus_model.sv */
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input wire clk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;
  end
  // released payload turns inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (lag) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input int lag);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "timebase_rtc_map.vh"
module testbench;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic crystalTick = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire tick1kHz, tick2kHz, interruptRequest, watchdogReset;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int wdCount = 0;
  int n1, n2, t;
  logic [31:0] v;
  exp_t e;
  exp_t rq[$];
  logic [1:0] bq[$];
  initial begin
    forever #10 clk = ~clk;
  end
  timebase_rtc_watchdog u_timebase_rtc_watchdog (
    .clk, .reset, .crystalTick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tick1kHz, .tick2kHz, .interruptRequest, .watchdogReset
  );
  cpu_bus_model u_cpu (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready
  );
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    u_cpu.wr(a, d, $urandom_range(2));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    rq.push_back('{d, m, (a > `OFS_SERVICE || a[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY});
    u_cpu.rd(a, $urandom_range(2));
  endtask
  // waiting with the watchdog fed well inside its shortest timeout
  task automatic idle(input int n);
    repeat (n / 4000) begin
      wr(`OFS_SERVICE, $urandom, `RESP_OKAY);
      repeat (4000) @(posedge clk);
    end
  endtask
  task automatic ticks(input int n);
    n1 = 0;
    n2 = 0;
    repeat (n) begin
      @(posedge clk);
      n1 += int'(tick1kHz === 1'b1);
      n2 += int'(tick2kHz === 1'b1);
    end
    chk("1 kHz count", 32'h1, 32'(n1 >= 99 && n1 <= 101));
    chk("2 kHz count", 32'h1, 32'(n2 >= 199 && n2 <= 201));
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (watchdogReset === 1'b1)
      wdCount <= wdCount + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rq.pop_front();
      chk("rdata", e.d & e.m, s_axi_rdata & e.m);
      chk("rresp", 32'(e.r), 32'(s_axi_rresp));
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
    if (cyc == 95000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(31));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    crystalTick <= 1'b1;
    @(posedge clk);
    rd(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h0, 32'hFF);
    rd(`OFS_RTCSR, 32'h0, 32'hFF);
    rd(8'h28, 32'h0, 32'hFFFFFFFF);
    rd(8'h06, 32'h0, 32'hFFFFFFFF);
    wr(8'h28, $urandom, `RESP_SLVERR);
    ticks(3840);
    // first write locks rate 00, later rate bits ignored
    wr(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h81, `RESP_OKAY);
    wr(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h99, `RESP_OKAY);
    rd(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h81, 32'hFF);
    wr(`OFS_TIMEBASE_CONTROL_REGISTER, 32'hC1, `RESP_OKAY);
    rd(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h81, 32'hFF);
    ticks(3200);
    v = $urandom_range(59);
    wr(`OFS_ALMIN, v, `RESP_OKAY);
    rd(`OFS_ALMIN, v, 32'hFF);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_RTCCR, k, `RESP_OKAY);
      rd(`OFS_RTCCR, k, 32'hFF);
    end
    rd(`OFS_RTCSR, 32'h0, 32'h0);
    idle(12000);
    rd(`OFS_RTCSR, 32'h1, 32'h1);
    wr(`OFS_RTCCR, 32'h0, `RESP_OKAY);
    rd(`OFS_RTCSR, 32'h0, 32'h0);
    idle(12000);
    rd(`OFS_RTCSR, 32'h0, 32'h1);
    wr(`OFS_RTCCR, 32'h18, `RESP_OKAY);
    idle(8000);
    chk("irq with chronograph", 32'h1, 32'(interruptRequest));
    rd(`OFS_RTCSR, 32'h4, 32'h4);
    wr(`OFS_RTCCR, 32'h08, `RESP_OKAY);
    idle(4000);
    chk("irq masked", 32'h0, 32'(interruptRequest));
    wr(`OFS_TIMEBASE_CONTROL_REGISTER, 32'hA1, `RESP_OKAY);
    rd(`OFS_CHRON, 32'h0, 32'hFF);
    wr(`OFS_ALMIN, 32'h1, `RESP_OKAY);
    wr(`OFS_ALMIN, 32'h0, `RESP_OKAY);
    rd(`OFS_RTCSR, 32'h2, 32'h2);
    wr(`OFS_TIMEBASE_CONTROL_REGISTER, 32'h81, `RESP_OKAY);
    chk("watchdog while fed", 32'h0, 32'(wdCount));
    wr(`OFS_SERVICE, $urandom, `RESP_OKAY);
    t = 0;
    while (watchdogReset !== 1'b1) begin
      @(posedge clk);
      t++;
    end
    chk("watchdog timeout", 32'h1, 32'(t >= 22000 && t <= 32400));
    test_done();
  end
endmodule
